//--- test_watchdog_reset_control.sv
// Self-checking bench for the reset and watchdog control top.
// Assumes the checker binds itself; inputs change on the rising edge.
`timescale 1ns/1ps
module test_watchdog_reset_control;
  localparam logic [15:0] TOUT = 16'h0008;
  logic       clk = 1'b0;
  logic       rst_b = 1'b0;
  logic       por_ok = 1'b1;
  logic       ext_reset_b = 1'b1;
  logic       bod_en = 1'b0;
  logic       bod_low = 1'b0;
  logic       osc_run = 1'b0;
  logic       fuse = 1'b0;
  logic       ce = 1'b1;
  logic       ctrl_wr = 1'b0;
  logic [4:0] ctrl_wdata = 5'h00;
  logic       kick = 1'b0;
  logic       flag_wr = 1'b0;
  logic       flag_wdata = 1'b0;
  logic       wdt_osc, core_reset, pulse, flag, trip;
  logic [4:0] rdata;
  int         fail_count = 0;
  int         checks_done = 0;
  int         n;
  always #25 clk = ~clk;
  wrc_far_model u_far (.clk(clk), .run(osc_run), .wdt_osc(wdt_osc));
  wrc_top dut (
    .clk(clk), .rst_b(rst_b), .ce(ce), .por_ok(por_ok), .ext_reset_b(ext_reset_b),
    .bod_en(bod_en), .bod_low(bod_low), .wdt_osc(wdt_osc), .always_on_fuse(fuse),
    .startup_timeout(TOUT), .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata), .kick(kick),
    .flag_wr(flag_wr), .flag_wdata(flag_wdata), .core_reset(core_reset),
    .wdog_reset_pulse(pulse), .ctrl_rdata(rdata), .watchdog_cause_flag(flag),
    .brownout_trip(trip)
  );
  // ********
  // Access tasks
  // ********
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [4:0] d, input logic flag_side);
    @(posedge clk);
    ctrl_wr    <= !flag_side;
    flag_wr    <= flag_side;
    ctrl_wdata <= d;
    flag_wdata <= d[0];
    @(posedge clk);
    ctrl_wr <= 1'b0;
    flag_wr <= 1'b0;
    @(negedge clk);
  endtask
  // Counts clocks until reset lets go, then judges the stretch
  task automatic release_chk(input string what);
    n = 0;
    while (core_reset !== 1'b0 && n < 500) begin
      @(negedge clk);
      n++;
    end
    chk(what, 16'h0001, 16'(n > TOUT && n < 20));
  endtask
  task automatic chip_reset(input logic f);
    @(posedge clk);
    rst_b <= 1'b0;
    fuse  <= f;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    release_chk("reset release");
  endtask
  // Entry: pause nibble, write data byte, expected readback byte
  task automatic seq(input logic [19:0] tbl [$]);
    foreach (tbl[i]) begin
      if (tbl[i][16]) repeat (5) @(posedge clk);
      wr(tbl[i][12:8], 1'b0);
      chk("control readback", 16'(tbl[i][4:0]), 16'(rdata));
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // ********
  // Tests
  // ********
  initial begin
    chip_reset(1'b0);
    chk("level 1 start", 16'h0000, 16'(rdata));
    seq('{20'h0_0808, 20'h0_0008, 20'h0_0308, 20'h0_1818,
          20'h0_0515, 20'h1_080D, 20'h0_181D, 20'h1_000D,
          20'h0_181D, 20'h0_0818});
    $display("test level 1 control done");
    @(posedge clk);
    osc_run <= 1'b1;
    repeat (4000) @(posedge clk);
    kick <= 1'b1;
    @(posedge clk);
    kick <= 1'b0;
    n = 0;
    while (pulse !== 1'b1 && n < 70000) begin
      @(negedge clk);
      n++;
    end
    chk("watchdog period", 16'h0001, 16'(n >= 65530 && n <= 65545));
    @(negedge clk);
    chk("pulse then reset", 16'h0003, 16'({pulse, core_reset, flag}));
    release_chk("watchdog release");
    osc_run <= 1'b0;
    chk("control after expiry", 16'h0000, 16'(rdata));
    wr(5'h01, 1'b1);
    chk("cause flag kept", 16'h0001, 16'(flag));
    wr(5'h00, 1'b1);
    chk("cause flag cleared", 16'h0000, 16'(flag));
    $display("test watchdog expiry done");
    @(posedge clk);
    bod_en  <= 1'b1;
    bod_low <= 1'b1;
    repeat (39) @(posedge clk);
    bod_low <= 1'b0;
    repeat (5) @(negedge clk);
    chk("short dip", 16'h0000, 16'({trip, core_reset}));
    @(posedge clk);
    bod_low <= 1'b1;
    repeat (60) @(posedge clk);
    #5;
    chk("long dip", 16'h0003, 16'({trip, core_reset}));
    @(posedge clk);
    bod_low <= 1'b0;
    release_chk("brown-out release");
    $display("test brown-out done");
    @(posedge clk);
    ext_reset_b <= 1'b0;
    #5;
    chk("pin reset", 16'h0001, 16'(core_reset));
    @(posedge clk);
    ext_reset_b <= 1'b1;
    release_chk("pin release");
    @(posedge clk);
    por_ok <= 1'b0;
    #5;
    chk("supply reset", 16'h0001, 16'(core_reset));
    @(posedge clk);
    por_ok <= 1'b1;
    release_chk("supply release");
    $display("test reset sources done");
    chip_reset(1'b1);
    chk("level 2 start", 16'h0008, 16'(rdata));
    seq('{20'h0_0008, 20'h0_1818, 20'h0_031B,
          20'h1_060B, 20'h0_100B, 20'h0_050B});
    // Unlock written while frozen must not open a window
    @(posedge clk);
    ce <= 1'b0;
    wr(5'h18, 1'b0);
    chk("frozen unlock", 16'h000B, 16'(rdata));
    @(posedge clk);
    ce <= 1'b1;
    wr(5'h06, 1'b0);
    chk("no window after freeze", 16'h000B, 16'(rdata));
    $display("test level 2 control done");
    end_sim();
  end
  initial begin
    repeat (95000) @(posedge clk);
    fail_count++;
    $display("BAD run length expected end seen hang");
    end_sim();
  end
endmodule // test_watchdog_reset_control

//--- wrc_far_model.sv
// Far side stand-in: the separate watchdog oscillator.
// Assumes the bench starts and stops it; it stops low.
`timescale 1ns/1ps
module wrc_far_model (
  input  wire logic clk,     // System clock
  input  wire logic run,     // Oscillator running
  output logic      wdt_osc  // Oscillator level
);
  logic [1:0] div_r = 2'h0;
  // Own rate, four system clocks a period, no tie to core activity
  always_ff @(posedge clk) begin
    div_r <= run ? div_r + 2'h1 : 2'h0;
  end
  assign wdt_osc = div_r[1];
endmodule // wrc_far_model

//--- wrc_if.sv
// Carrier between the control top and its watchdog counter and reset stretcher.
// Assumes all three modules share one clock.
`timescale 1ns/1ps
interface wrc_if;
  logic                            wd_en;
  logic                            wd_clr;
  logic                            wd_osc;
  logic [wrc_pkg::SEL_W-1:0]       wd_sel;
  logic                            wd_expire;
  logic                            st_hold;
  logic [wrc_pkg::TOUT_W-1:0]      st_tout;
  logic                            st_done;

  modport ctl (output wd_en, wd_clr, wd_osc, wd_sel, st_hold, st_tout,
               input  wd_expire, st_done);
  modport wd  (input  wd_en, wd_clr, wd_osc, wd_sel, output wd_expire);
  modport st  (input  st_hold, st_tout, output st_done);
endinterface

//--- wrc_pkg.sv
// Shared constants, field layout and types of the reset and watchdog control block.
// Assumes a single 20 MHz system clock; every user names items as wrc_pkg::name.
package wrc_pkg;

  // ***************************************************************
  // Clock and timing
  // ***************************************************************
  localparam int unsigned CLK_HZ      = 20_000_000;
  localparam int unsigned BOD_MIN_NS  = 2000;
  // Least time, rounded up to whole clock cycles
  localparam int unsigned BOD_MIN_CYC =
    (BOD_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned BOD_CW      = 8;
  localparam logic [BOD_CW-1:0] BOD_LIMIT = BOD_MIN_CYC[BOD_CW-1:0];

  // ***************************************************************
  // Control word layout
  // ***************************************************************
  localparam int unsigned CTRL_W     = 5;
  localparam int unsigned UNLOCK_POS = 4;
  localparam int unsigned ON_POS     = 3;
  localparam int unsigned SEL_LSB    = 0;
  localparam int unsigned SEL_W      = 3;
  localparam logic [2:0]  UNLOCK_CYC = 3'h4;
  localparam logic [SEL_W-1:0] SEL_RST = 3'h0;

  // ***************************************************************
  // Watchdog period and start-up delay
  // ***************************************************************
  localparam int unsigned WD_CW        = 21;
  localparam int unsigned WD_BASE_LOG2 = 14;
  localparam int unsigned TOUT_W       = 16;

  typedef enum logic [1:0] {ST_HOLD, ST_COUNT, ST_DONE} wrc_st_type;

  // Last count of a period: 16K oscillator cycles doubled per code step
  function automatic logic [WD_CW-1:0] wd_last(input logic [SEL_W-1:0] sel);
    logic [WD_CW:0] one_hot;
    one_hot = '0;
    one_hot[WD_BASE_LOG2 + int'(sel)] = 1'b1;
    wd_last = one_hot[WD_CW-1:0] - 1'b1;
  endfunction

endpackage

//--- wrc_stretch.sv
// Reset stretcher: holds reset until the start-up delay has counted out.
// Assumes its async reset is the OR of every asynchronous reset source.
`timescale 1ns/1ps
module wrc_stretch (
  input wire logic clk,    // System clock
  input wire logic src_b,  // Async reset sources combined, active low
  input wire logic ce,     // Clock enable
  wrc_if.st        bus     // Control side
);

  // ***************************************************************
  // Delay counter
  // ***************************************************************
  wrc_pkg::wrc_st_type          st_r;
  wrc_pkg::wrc_st_type          st_nxt;
  logic [wrc_pkg::TOUT_W-1:0]   cnt_r;
  logic [wrc_pkg::TOUT_W-1:0]   tout_r;

  wire counted = (cnt_r == tout_r);

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      wrc_pkg::ST_HOLD:  if (!bus.st_hold) st_nxt = wrc_pkg::ST_COUNT;
      wrc_pkg::ST_COUNT: if (bus.st_hold) st_nxt = wrc_pkg::ST_HOLD;
                         else if (counted) st_nxt = wrc_pkg::ST_DONE;
      default:           if (bus.st_hold) st_nxt = wrc_pkg::ST_HOLD;
    endcase
  end

  always_ff @(posedge clk or negedge src_b) begin
    if (!src_b) begin
      st_r   <= wrc_pkg::ST_HOLD;
      cnt_r  <= '0;
      tout_r <= '0;
    end else if (ce) begin
      st_r  <= st_nxt;
      cnt_r <= (st_r == wrc_pkg::ST_COUNT) ? cnt_r + 1'b1 : '0;
      // Length caught on every hold cycle, so it stays fixed while counting
      if (st_r == wrc_pkg::ST_HOLD) tout_r <= bus.st_tout;
    end
  end

  assign bus.st_done = (st_r == wrc_pkg::ST_DONE);

endmodule // wrc_stretch

//--- wrc_top.sv
// Reset generation and watchdog control of a small microcontroller.
// Assumes all inputs are synchronous to clk except the reset sources,
// which act asynchronously; the core writes control bits as one-cycle strobes.
`timescale 1ns/1ps
module wrc_top (
  input  wire logic                        clk,              // 20 MHz system clock
  input  wire logic                        rst_b,            // Async reset, active low
  input  wire logic                        ce,               // Clock enable
  input  wire logic                        por_ok,           // Supply above POR level
  input  wire logic                        ext_reset_b,      // Reset pin, active low
  input  wire logic                        bod_en,           // Brown-out detector on
  input  wire logic                        bod_low,          // Supply below lower level
  input  wire logic                        wdt_osc,          // Watchdog oscillator
  input  wire logic                        always_on_fuse,   // Safety level 2 when high
  input  wire logic [wrc_pkg::TOUT_W-1:0]  startup_timeout,  // Delay in clocks
  input  wire logic                        ctrl_wr,          // Control write strobe
  input  wire logic [wrc_pkg::CTRL_W-1:0]  ctrl_wdata,       // Control write data
  input  wire logic                        kick,             // Kick instruction
  input  wire logic                        flag_wr,          // Cause flag write strobe
  input  wire logic                        flag_wdata,       // Cause flag write value
  output logic                             core_reset,       // Internal reset, high
  output logic                             wdog_reset_pulse, // One-clock expiry pulse
  output logic [wrc_pkg::CTRL_W-1:0]       ctrl_rdata,       // Control readback
  output logic                             watchdog_cause_flag, // Last reset by watchdog
  output logic                             brownout_trip     // Filtered brown-out
);

  // ***************************************************************
  // Reset sources
  // ***************************************************************
  // Pin and supply act without the clock; short pin pulses also reset
  wire src_b = rst_b & por_ok & ext_reset_b;
  wire pwr_b = rst_b & por_ok;

  // ***************************************************************
  // Brown-out filter
  // ***************************************************************
  logic [wrc_pkg::BOD_CW-1:0] bod_cnt_r;
  logic [wrc_pkg::BOD_CW-1:0] bod_cnt_nxt;
  logic                       bod_trip_r;

  wire bod_seen   = bod_en & bod_low;
  wire bod_full   = (bod_cnt_r == wrc_pkg::BOD_LIMIT);
  assign bod_cnt_nxt = !bod_seen ? '0 :
                       bod_full  ? bod_cnt_r : bod_cnt_r + 1'b1;
  // Trip once persistent; drop as soon as the supply recovers
  wire bod_trip_nxt = bod_seen & bod_full;

  always_ff @(posedge clk or negedge pwr_b) begin
    if (!pwr_b) begin
      bod_cnt_r  <= '0;
      bod_trip_r <= 1'b0;
    end else if (ce) begin
      bod_cnt_r  <= bod_cnt_nxt;
      bod_trip_r <= bod_trip_nxt;
    end
  end

  // ***************************************************************
  // Sub-blocks
  // ***************************************************************
  wrc_if link ();

  wrc_wdog u_wdog (
    .clk   (clk),
    .rst_b (rst_b),
    .ce    (ce),
    .bus   (link.wd)
  );

  wrc_stretch u_stretch (
    .clk   (clk),
    .src_b (src_b),
    .ce    (ce),
    .bus   (link.st)
  );

  // ***************************************************************
  // Watchdog pulse and internal reset
  // ***************************************************************
  logic wd_pulse_r;
  logic core_reset_r;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wd_pulse_r <= 1'b0;
    end else if (ce) begin
      // Expiry is a single-cycle strobe, so the pulse is one clock wide
      wd_pulse_r <= link.wd_expire;
    end
  end

  always_ff @(posedge clk or negedge src_b) begin
    if (!src_b) begin
      core_reset_r <= 1'b1;
    end else if (ce) begin
      // Hold request covers the cycle before the stretcher leaves done
      core_reset_r <= ~link.st_done | link.st_hold;
    end
  end

  assign link.st_hold = bod_trip_r | wd_pulse_r;
  assign link.st_tout = startup_timeout;

  // ***************************************************************
  // Control write decode
  // ***************************************************************
  logic                      on_r;
  logic [wrc_pkg::SEL_W-1:0] sel_r;
  logic [2:0]                unlock_cnt_r;
  logic                      on_nxt;
  logic [wrc_pkg::SEL_W-1:0] sel_nxt;
  logic [2:0]                unlock_nxt;

  wire                      lvl2     = always_on_fuse;
  wire                      wr_unl   = ctrl_wdata[wrc_pkg::UNLOCK_POS];
  wire                      wr_on    = ctrl_wdata[wrc_pkg::ON_POS];
  wire [wrc_pkg::SEL_W-1:0] wr_sel   = ctrl_wdata[wrc_pkg::SEL_LSB +: wrc_pkg::SEL_W];
  wire                      win      = (unlock_cnt_r != 3'h0);
  wire                      unl_req  = ctrl_wr & wr_unl & wr_on;
  wire                      chg      = ctrl_wr & ~wr_unl & win;

  // Level 2 ignores the on value; the fuse forces enable anyway
  assign on_nxt = core_reset_r     ? 1'b0 :
                  chg              ? wr_on :
                  (ctrl_wr & wr_on) ? 1'b1 : on_r;
  assign sel_nxt = core_reset_r ? wrc_pkg::SEL_RST :
                   chg          ? wr_sel : sel_r;
  assign unlock_nxt = core_reset_r ? 3'h0 :
                      unl_req      ? wrc_pkg::UNLOCK_CYC :
                      win          ? unlock_cnt_r - 1'b1 : 3'h0;

  wire en_nxt = lvl2 | on_nxt;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      on_r         <= 1'b0;
      sel_r        <= wrc_pkg::SEL_RST;
      unlock_cnt_r <= 3'h0;
    end else if (ce) begin
      on_r         <= on_nxt;
      sel_r        <= sel_nxt;
      unlock_cnt_r <= unlock_nxt;
    end
  end

  assign link.wd_en  = lvl2 | on_r;
  assign link.wd_sel = sel_r;
  assign link.wd_osc = wdt_osc;
  assign link.wd_clr = kick | core_reset_r;

  // ***************************************************************
  // Readback and cause flag
  // ***************************************************************
  logic [wrc_pkg::CTRL_W-1:0] rdata_r;
  logic                       cause_r;
  logic                       bo_out_r;
  logic                       pulse_out_r;

  wire [wrc_pkg::CTRL_W-1:0] rdata_nxt = {(unlock_nxt != 3'h0), en_nxt, sel_nxt};

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_r     <= '0;
      bo_out_r    <= 1'b0;
      pulse_out_r <= 1'b0;
    end else if (ce) begin
      rdata_r     <= rdata_nxt;
      bo_out_r    <= bod_trip_nxt;
      pulse_out_r <= link.wd_expire;
    end
  end

  // Power-on clears; a set arriving with a software clear wins
  always_ff @(posedge clk or negedge pwr_b) begin
    if (!pwr_b) begin
      cause_r <= 1'b0;
    end else if (ce) begin
      if (wd_pulse_r) cause_r <= 1'b1;
      else if (flag_wr && !flag_wdata) cause_r <= 1'b0;
    end
  end

  assign core_reset          = core_reset_r;
  assign wdog_reset_pulse    = pulse_out_r;
  assign ctrl_rdata          = rdata_r;
  assign watchdog_cause_flag = cause_r;
  assign brownout_trip       = bo_out_r;

endmodule // wrc_top

//--- wrc_top_properties.sv
// Concurrent checks on the ports of the reset and watchdog control top.
// Assumes one clock domain; bound to every wrc_top below.
`timescale 1ns/1ps
module wrc_top_properties (
  input wire logic                       clk,                 // Clock
  input wire logic                       rst_b,               // Reset
  input wire logic                       ce,                  // Enable
  input wire logic                       por_ok,              // Supply ok
  input wire logic                       ext_reset_b,         // Pin
  input wire logic                       bod_en,              // Detector on
  input wire logic                       bod_low,             // Supply low
  input wire logic                       always_on_fuse,      // Level 2
  input wire logic [wrc_pkg::TOUT_W-1:0] startup_timeout,     // Delay
  input wire logic [wrc_pkg::CTRL_W-1:0] ctrl_rdata,          // Readback
  input wire logic                       core_reset,          // Reset out
  input wire logic                       wdog_reset_pulse,    // Expiry
  input wire logic                       watchdog_cause_flag, // Cause
  input wire logic                       brownout_trip        // Trip
);
  logic [7:0]  low_run_r;
  logic [16:0] rel_cnt_r;
  // ********
  // Run of low supply and time since last reset cause
  // ********
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      low_run_r <= 8'h00;
      rel_cnt_r <= 17'h0_0000;
    end else begin
      low_run_r <= (bod_en && bod_low) ? low_run_r + {7'h00, low_run_r != 8'hff} : 8'h00;
      rel_cnt_r <= (!por_ok || !ext_reset_b || wdog_reset_pulse || brownout_trip) ?
                   17'h0_0000 : rel_cnt_r + {16'h0000, rel_cnt_r != 17'h1_ffff};
    end
  end
  default clocking dcb @(posedge clk); endclocking
  default disable iff (!rst_b);
  chk_pulse_one_wide: assert property (wdog_reset_pulse |=> !wdog_reset_pulse)
    else $error("expiry pulse wider than one clock");
  chk_pulse_then_hold: assert property (ce && wdog_reset_pulse |=> core_reset)
    else $error("no reset after expiry pulse");
  chk_pulse_sets_cause: assert property (ce && wdog_reset_pulse |=> watchdog_cause_flag)
    else $error("cause flag not set by expiry");
  chk_supply_low_hold: assert property (!por_ok |-> core_reset && !watchdog_cause_flag)
    else $error("supply low without reset");
  chk_pin_low_hold: assert property (!ext_reset_b |-> core_reset)
    else $error("pin low without reset");
  chk_unlock_four_cycles: assert property ($rose(ctrl_rdata[4]) |-> ctrl_rdata[4] [*4] ##1 !ctrl_rdata[4])
    else $error("unlock window not four clocks");
  chk_level2_stays_on: assert property (always_on_fuse && !core_reset ##1 !core_reset |-> ctrl_rdata[3])
    else $error("on bit low at level 2");
  chk_dip_filter: assert property ($rose(brownout_trip) |-> low_run_r >= 8'h28)
    else $error("brown-out trip on a short dip");
  chk_trip_resets: assert property (brownout_trip |=> core_reset)
    else $error("brown-out trip without reset");
  chk_release_delay: assert property ($fell(core_reset) |-> rel_cnt_r >= {1'b0, startup_timeout})
    else $error("reset released before delay");
  cover property (wdog_reset_pulse);
  cover property ($rose(brownout_trip));
  cover property (always_on_fuse && $fell(core_reset));
endmodule // wrc_top_properties

bind wrc_top wrc_top_properties u_props (
  .clk(clk), .rst_b(rst_b), .ce(ce), .por_ok(por_ok), .ext_reset_b(ext_reset_b),
  .bod_en(bod_en), .bod_low(bod_low), .always_on_fuse(always_on_fuse),
  .startup_timeout(startup_timeout), .ctrl_rdata(ctrl_rdata), .core_reset(core_reset),
  .wdog_reset_pulse(wdog_reset_pulse), .watchdog_cause_flag(watchdog_cause_flag),
  .brownout_trip(brownout_trip)
);

//--- wrc_wdog.sv
// Watchdog counter: counts rising edges of the watchdog oscillator input.
// Assumes the oscillator level is synchronous to clk and far slower than it.
`timescale 1ns/1ps
module wrc_wdog (
  input wire logic clk,    // System clock
  input wire logic rst_b,  // Async reset, active low
  input wire logic ce,     // Clock enable
  wrc_if.wd        bus     // Control side
);

  // ***************************************************************
  // Oscillator edge and count
  // ***************************************************************
  logic                     osc_d_r;
  logic [wrc_pkg::WD_CW-1:0] cnt_r;
  logic [wrc_pkg::WD_CW-1:0] cnt_nxt;
  logic                     exp_r;

  wire                      tick = bus.wd_osc & ~osc_d_r;
  wire [wrc_pkg::WD_CW-1:0] last = wrc_pkg::wd_last(bus.wd_sel);
  // Compare with >= so a shorter period chosen mid-count still expires
  wire                      hit  = bus.wd_en & tick & (cnt_r >= last);

  assign cnt_nxt = (bus.wd_clr | ~bus.wd_en | hit) ? '0 :
                   tick ? cnt_r + 1'b1 : cnt_r;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      osc_d_r <= 1'b0;
      cnt_r   <= '0;
      exp_r   <= 1'b0;
    end else if (ce) begin
      osc_d_r <= bus.wd_osc;
      cnt_r   <= cnt_nxt;
      exp_r   <= hit;
    end
  end

  assign bus.wd_expire = exp_r;

endmodule // wrc_wdog
